/* File: src/ext_mode_pkg.sv */
// package: mode encodings, control bit positions, area windows and carriers
// assumes: 32-bit cpu addresses, one core clock
package ext_mode_pkg;
   localparam int CTRL_ROM_DISABLE_POS = 0;
   localparam int CTRL_BUS_ENABLE_POS = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam logic [31:0] AREA3_LO = 32'h05E0_0000;
   localparam logic [31:0] AREA3_HI = 32'h05FF_FFFF;
   localparam logic [31:0] AREA2_LO = 32'h06E0_0000;
   localparam logic [31:0] AREA2_HI = 32'h06FF_FFFF;
   localparam logic [31:0] AREA1_LO = 32'h07E0_0000;
   localparam logic [31:0] AREA1_HI = 32'h07FF_FFFF;
   localparam logic [31:0] AREA0_LO = 32'hFFE0_0000;
   localparam logic [31:0] AREA0_HI = 32'hFFFF_FFFF;
   localparam int NUM_AREAS = 4;

   typedef enum logic [1:0] {
      MODE_SINGLE_CHIP,
      MODE_ROM_ENABLED_EXT,
      MODE_ROM_DISABLED_EXT
   } op_mode_type;

   // which resource classes the cpu may reach
   typedef struct packed {
      logic io_regs;
      logic ram;
      logic rom;
      logic ext_areas;
   } access_type;

   // one bit per area select, index n is area n
   typedef struct packed {
      logic [NUM_AREAS-1:0] sel;
      logic cycle;
   } ext_req_type;
endpackage : ext_mode_pkg

/* File: src/area_window_decode.sv */
// area_window_decode: combinational window match of an address to area selects
// assumes: caller derives the enables from the operating mode
`timescale 1ns/1ps
`default_nettype none
module area_window_decode
(
   // address and enables
   input wire logic [31:0] i_addr,
   input wire logic i_ext_en,
   input wire logic i_area0_en,
   // matches
   output logic [ext_mode_pkg::NUM_AREAS-1:0] o_hit
);
   logic [31:0] lo [ext_mode_pkg::NUM_AREAS];
   logic [31:0] hi [ext_mode_pkg::NUM_AREAS];
   logic [ext_mode_pkg::NUM_AREAS-1:0] en;

   assign lo[0] = ext_mode_pkg::AREA0_LO;
   assign hi[0] = ext_mode_pkg::AREA0_HI;
   assign lo[1] = ext_mode_pkg::AREA1_LO;
   assign hi[1] = ext_mode_pkg::AREA1_HI;
   assign lo[2] = ext_mode_pkg::AREA2_LO;
   assign hi[2] = ext_mode_pkg::AREA2_HI;
   assign lo[3] = ext_mode_pkg::AREA3_LO;
   assign hi[3] = ext_mode_pkg::AREA3_HI;
   assign en = {i_ext_en, i_ext_en, i_ext_en, i_ext_en & i_area0_en};

   genvar n;
   generate
      for (n = 0; n < ext_mode_pkg::NUM_AREAS; n++)
      begin : g_win
         assign o_hit[n] = en[n] & (i_addr >= lo[n]) & (i_addr <= hi[n]);
      end
   endgenerate
endmodule : area_window_decode
`default_nettype wire

/* File: src/extended_mode_area_decode.sv */
// extended_mode_area_decode: mode selection from software bits and area select decode
// assumes: cpu presents an address with a request strobe each cycle; selects registered
`timescale 1ns/1ps
`default_nettype none
module extended_mode_area_decode
(
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_rstn,
   // control word write
   input wire logic i_ctrl_wr,
   input wire logic [1:0] i_ctrl_wdata,
   // cpu access
   input wire logic i_req,
   input wire logic [31:0] i_addr,
   // mode and access status
   output logic [1:0] o_system_control_word_0,
   output ext_mode_pkg::op_mode_type o_mode,
   output ext_mode_pkg::access_type o_access,
   output logic o_rom_startup,
   // external bus
   output logic o_area0_select,
   output logic o_area1_select,
   output logic o_area2_select,
   output logic o_area3_select,
   output logic o_ext_cycle
);
   //////////////////////////////////////////////////////////////////////////////
   logic [1:0] ctrl;
   logic onchip_rom_disable_bit;
   logic external_bus_enable_bit;
   ext_mode_pkg::op_mode_type next_mode;
   ext_mode_pkg::access_type next_access;
   logic [ext_mode_pkg::NUM_AREAS-1:0] hit;
   ext_mode_pkg::ext_req_type next_req;
   logic ext_en;

   assign onchip_rom_disable_bit = ctrl[ext_mode_pkg::CTRL_ROM_DISABLE_POS];
   assign external_bus_enable_bit = ctrl[ext_mode_pkg::CTRL_BUS_ENABLE_POS];

   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         ctrl <= ext_mode_pkg::CTRL_RESET;
      else if (i_ctrl_wr)
         ctrl <= i_ctrl_wdata;
   end

   //////////////////////////////////////////////////////////////////////////////
   // mode from bits
   always_comb
   begin
      case ({onchip_rom_disable_bit, external_bus_enable_bit})
         2'h1: next_mode = ext_mode_pkg::MODE_ROM_ENABLED_EXT;
         2'h3: next_mode = ext_mode_pkg::MODE_ROM_DISABLED_EXT;
         default: next_mode = ext_mode_pkg::MODE_SINGLE_CHIP;
      endcase
   end

   always_comb
   begin
      next_access.io_regs = 1'b1;
      next_access.ram = 1'b1;
      next_access.rom = next_mode != ext_mode_pkg::MODE_ROM_DISABLED_EXT;
      next_access.ext_areas = next_mode != ext_mode_pkg::MODE_SINGLE_CHIP;
   end

   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         o_mode <= ext_mode_pkg::MODE_SINGLE_CHIP;
         o_access <= '{io_regs: 1'b1, ram: 1'b1, rom: 1'b1, ext_areas: 1'b0};
         o_system_control_word_0 <= ext_mode_pkg::CTRL_RESET;
      end
      else
      begin
         o_mode <= next_mode;
         o_access <= next_access;
         o_system_control_word_0 <= ctrl;
      end
   end

   // rom reachable at startup, until rom-disabled mode taken
   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         o_rom_startup <= 1'b1;
      else if (next_mode == ext_mode_pkg::MODE_ROM_DISABLED_EXT)
         o_rom_startup <= 1'b0;
   end

   //////////////////////////////////////////////////////////////////////////////
   assign ext_en = next_mode != ext_mode_pkg::MODE_SINGLE_CHIP;

   area_window_decode u_win
   (
      .i_addr(i_addr),
      .i_ext_en(ext_en),
      .i_area0_en(next_mode == ext_mode_pkg::MODE_ROM_DISABLED_EXT),
      .o_hit(hit)
   );

   always_comb
   begin
      next_req.sel = i_req ? hit : '0;
      next_req.cycle = |next_req.sel;
   end

   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         o_area0_select <= 1'b0;
         o_area1_select <= 1'b0;
         o_area2_select <= 1'b0;
         o_area3_select <= 1'b0;
         o_ext_cycle <= 1'b0;
      end
      else
      begin
         o_area0_select <= next_req.sel[0];
         o_area1_select <= next_req.sel[1];
         o_area2_select <= next_req.sel[2];
         o_area3_select <= next_req.sel[3];
         o_ext_cycle <= next_req.cycle;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   sequence s_ext_req(logic [31:0] lo, logic [31:0] hi);
      i_req && ext_en && i_addr >= lo && i_addr <= hi;
   endsequence

   property p_mode_rom_en;
      @(posedge i_core_clk) disable iff (!i_rstn)
      (i_ctrl_wr && i_ctrl_wdata == 2'h2) ##1 !i_ctrl_wr
         |=> o_mode == ext_mode_pkg::MODE_ROM_ENABLED_EXT;
   endproperty
   a_mode_rom_en: assert property (p_mode_rom_en) else $error("bad rom-enabled mode");

   property p_mode_rom_dis;
      @(posedge i_core_clk) disable iff (!i_rstn)
      (i_ctrl_wr && i_ctrl_wdata == 2'h3) ##1 !i_ctrl_wr
         |=> o_mode == ext_mode_pkg::MODE_ROM_DISABLED_EXT;
   endproperty
   a_mode_rom_dis: assert property (p_mode_rom_dis) else $error("bad rom-disabled mode");

   property p_mode_hold;
      @(posedge i_core_clk) disable iff (!i_rstn)
      !i_ctrl_wr |=> $stable(ctrl);
   endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("mode changed without write");

   property p_area3;
      @(posedge i_core_clk) disable iff (!i_rstn)
      s_ext_req(ext_mode_pkg::AREA3_LO, ext_mode_pkg::AREA3_HI) |=> o_area3_select && o_ext_cycle;
   endproperty
   a_area3: assert property (p_area3) else $error("area 3 not selected");

   property p_area2;
      @(posedge i_core_clk) disable iff (!i_rstn)
      s_ext_req(ext_mode_pkg::AREA2_LO, ext_mode_pkg::AREA2_HI) |=> o_area2_select && o_ext_cycle;
   endproperty
   a_area2: assert property (p_area2) else $error("area 2 not selected");

   property p_area1;
      @(posedge i_core_clk) disable iff (!i_rstn)
      s_ext_req(ext_mode_pkg::AREA1_LO, ext_mode_pkg::AREA1_HI) |=> o_area1_select && o_ext_cycle;
   endproperty
   a_area1: assert property (p_area1) else $error("area 1 not selected");

   property p_area0;
      @(posedge i_core_clk) disable iff (!i_rstn)
      o_area0_select |-> o_mode == ext_mode_pkg::MODE_ROM_DISABLED_EXT && !o_access.rom;
   endproperty
   a_area0: assert property (p_area0) else $error("area 0 outside rom-disabled mode");

   property p_single_quiet;
      @(posedge i_core_clk) disable iff (!i_rstn)
      !ext_en |=> !o_ext_cycle && !o_area0_select && !o_area1_select
         && !o_area2_select && !o_area3_select;
   endproperty
   a_single_quiet: assert property (p_single_quiet) else $error("single-chip cycle");

   property p_rom_access;
      @(posedge i_core_clk) disable iff (!i_rstn)
      o_mode == ext_mode_pkg::MODE_ROM_ENABLED_EXT |-> o_access.rom && o_access.ext_areas;
   endproperty
   a_rom_access: assert property (p_rom_access) else $error("rom-enabled access wrong");

   sequence s_top_req;
      i_req && next_mode == ext_mode_pkg::MODE_ROM_DISABLED_EXT
         && i_addr >= ext_mode_pkg::AREA0_LO;
   endsequence

   property p_area0_hit;
      @(posedge i_core_clk) disable iff (!i_rstn)
      s_top_req |=> o_area0_select && o_ext_cycle;
   endproperty
   a_area0_hit: assert property (p_area0_hit) else $error("area 0 not selected");

   property p_unmapped_quiet;
      @(posedge i_core_clk) disable iff (!i_rstn)
      (i_req && i_addr < ext_mode_pkg::AREA3_LO) |=> !o_ext_cycle;
   endproperty
   a_unmapped_quiet: assert property (p_unmapped_quiet) else $error("unmapped cycle");

   property p_rom_kept;
      @(posedge i_core_clk) disable iff (!i_rstn)
      !o_rom_startup |=> !o_rom_startup;
   endproperty
   a_rom_kept: assert property (p_rom_kept) else $error("startup rom came back");
endmodule : extended_mode_area_decode
`default_nettype wire

/* File: testbench/ext_memory_model.sv */
// ext_memory_model: external devices sitting behind the four area selects
// assumes: selects registered, active high, one cycle per access
`timescale 1ns/1ps
`default_nettype none
module ext_memory_model
(
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_rstn,
   // area selects, index n is area n
   input wire logic [3:0] i_sel,
   // accesses seen
   output logic [15:0] o_count
);
   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         o_count <= 16'h0;
      else if (|i_sel)
         o_count <= o_count + 16'h1;
   end
endmodule : ext_memory_model
`default_nettype wire

/* File: testbench/extended_mode_area_decode_tb_top.sv */
// testbench: mode writes, window corners and random addresses
// assumes: selects one edge after request, mode two edges after control word write
`timescale 1ns/1ps
`default_nettype none
module extended_mode_area_decode_tb_top;
   logic i_core_clk = 1'b0;
   logic i_rstn = 1'b0;
   logic i_ctrl_wr = 1'b0;
   logic [1:0] i_ctrl_wdata = 2'h0;
   logic i_req = 1'b0;
   logic [31:0] i_addr = 32'h0;
   logic [1:0] ctrl;
   ext_mode_pkg::op_mode_type mode, expm;
   ext_mode_pkg::access_type acc;
   logic rom_st, cyc;
   logic [3:0] sel;
   logic [15:0] mem_count;
   int err_count = 0;
   int n_tests = 0;
   int n_ext = 0;
   logic [31:0] rnd = 32'h5448;
   logic [31:0] corner [12] = '{32'h05DF_FFFF, 32'h05E0_0000, 32'h05FF_FFFF, 32'h0600_0000,
      32'h06E0_0000, 32'h06FF_FFFF, 32'h07E0_0000, 32'h07FF_FFFF, 32'hFFDF_FFFF,
      32'hFFE0_0000, 32'hFFFF_FFFF, 32'h0000_0000};
   logic [7:0] tops [4] = '{8'h05, 8'h06, 8'h07, 8'hFF};

   always #5 i_core_clk = ~i_core_clk;

   extended_mode_area_decode u_dut (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
      .i_ctrl_wr(i_ctrl_wr), .i_ctrl_wdata(i_ctrl_wdata), .i_req(i_req), .i_addr(i_addr),
      .o_system_control_word_0(ctrl), .o_mode(mode), .o_access(acc), .o_rom_startup(rom_st),
      .o_area0_select(sel[0]), .o_area1_select(sel[1]), .o_area2_select(sel[2]),
      .o_area3_select(sel[3]), .o_ext_cycle(cyc));

   ext_memory_model u_mem (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_sel(sel),
      .o_count(mem_count));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   function automatic logic [3:0] exp_sel(input logic [31:0] a);
      logic [3:0] s;
      s = 4'h0;
      if (expm != ext_mode_pkg::MODE_SINGLE_CHIP)
      begin
         s[3] = (a >= 32'h05E0_0000) && (a <= 32'h05FF_FFFF);
         s[2] = (a >= 32'h06E0_0000) && (a <= 32'h06FF_FFFF);
         s[1] = (a >= 32'h07E0_0000) && (a <= 32'h07FF_FFFF);
         s[0] = (expm == ext_mode_pkg::MODE_ROM_DISABLED_EXT) && (a >= 32'hFFE0_0000);
      end
      return s;
   endfunction : exp_sel

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask : chk

   task automatic access(input logic [31:0] a);
      logic [3:0] e;
      e = exp_sel(a);
      @(posedge i_core_clk);
      i_req <= 1'b1;
      i_addr <= a;
      @(posedge i_core_clk);
      i_req <= 1'b0;
      #1;
      chk("selects", {28'h0, e}, {28'h0, sel});
      chk("ext_cycle", {31'h0, |e}, {31'h0, cyc});
      n_ext += (|e) ? 1 : 0;
   endtask : access

   task automatic sweep();
      for (int i = 0; i < 12; i++)
         access(corner[i]);
      for (int i = 0; i < 40; i++)
      begin
         rnd = lfsr(rnd);
         access(rnd[27] ? rnd : {tops[rnd[25:24]], rnd[23:0]});
      end
   endtask : sweep

   task automatic wr_ctrl(input logic [1:0] v, input ext_mode_pkg::op_mode_type m);
      @(posedge i_core_clk);
      i_ctrl_wr <= 1'b1;
      i_ctrl_wdata <= v;
      @(posedge i_core_clk);
      i_ctrl_wr <= 1'b0;
      @(posedge i_core_clk);
      #1;
      expm = m;
      chk("ctrl_word", {30'h0, v}, {30'h0, ctrl});
      chk("mode", {30'h0, m}, {30'h0, mode});
   endtask : wr_ctrl

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : tally_and_finish

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      #200000;
      err_count++;
      tally_and_finish();
   end

   initial
   begin
      expm = ext_mode_pkg::MODE_SINGLE_CHIP;
      repeat (12) @(posedge i_core_clk);
      i_rstn <= 1'b1;
      #1;
      chk("reset_mode", {30'h0, ext_mode_pkg::MODE_SINGLE_CHIP}, {30'h0, mode});
      chk("reset_access", 32'hE, {28'h0, acc});
      chk("reset_rom_startup", 32'h1, {31'h0, rom_st});
      sweep();
      $display("test single chip done");
      wr_ctrl(2'h2, ext_mode_pkg::MODE_ROM_ENABLED_EXT);
      chk("access_rom_en", 32'hF, {28'h0, acc});
      chk("rom_startup_rom_en", 32'h1, {31'h0, rom_st});
      sweep();
      $display("test rom enabled done");
      // bench acts as software running from on-chip ram
      wr_ctrl(2'h3, ext_mode_pkg::MODE_ROM_DISABLED_EXT);
      chk("access_rom_dis", 32'hD, {28'h0, acc});
      chk("rom_startup", 32'h0, {31'h0, rom_st});
      sweep();
      $display("test rom disabled done");
      wr_ctrl(2'h1, ext_mode_pkg::MODE_SINGLE_CHIP);
      wr_ctrl(2'h0, ext_mode_pkg::MODE_SINGLE_CHIP);
      sweep();
      chk("rom_startup_kept", 32'h0, {31'h0, rom_st});
      chk("memory_accesses", n_ext, {16'h0, mem_count});
      $display("test back to single chip done");
      tally_and_finish();
   end
endmodule : extended_mode_area_decode_tb_top
`default_nettype wire
